// ### common/vfd_pkg.sv
// Shared constants and types for the serial display driver.
// Assumes a 25 MHz system clock; the pin-side shift clock is sampled.
package vfd_pkg;

    // ------------------------------------------------------------------
    // Variants and output counts
    // ------------------------------------------------------------------
    typedef enum logic {
        VFD_MODE_START,
        VFD_MODE_ENABLE
    } vfd_mode_type;

    localparam int START_OUTPUTS = 35;     // Start-bit variant width
    localparam int EN_OUTPUTS_SMALL = 20;  // Enable variant, short
    localparam int EN_OUTPUTS_LARGE = 32;  // Enable variant, long

    // ------------------------------------------------------------------
    // Event word carried through the FIFO
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W     = 4;
    localparam int W_DATA     = 0;         // Sampled serial bit
    localparam int W_SHIFT    = 1;         // Rising shift-clock edge
    localparam int W_LOAD     = 2;         // Falling enable edge
    localparam int W_FALL     = 3;         // Falling shift-clock edge
    localparam int SYNC_W     = 4;
    localparam int P_DATA     = 0;         // Synchroniser lanes
    localparam int P_CLK      = 1;
    localparam int P_EN       = 2;
    localparam int P_BLANK    = 3;

    // ------------------------------------------------------------------
    // Timing: shortest legal shift-clock period, in system cycles
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ   = 25_000_000;
    localparam int START_MAX_HZ = 1_000_000;
    localparam int EN_MAX_HZ    = 800_000;
    localparam int RATE_CNT_W   = 6;
    localparam int START_MIN_CYC_I =
        (SYS_CLK_HZ + START_MAX_HZ - 1) / START_MAX_HZ;
    localparam int EN_MIN_CYC_I =
        (SYS_CLK_HZ + EN_MAX_HZ - 1) / EN_MAX_HZ;
    localparam logic [RATE_CNT_W-1:0] START_MIN_CYC =
        RATE_CNT_W'(START_MIN_CYC_I);
    localparam logic [RATE_CNT_W-1:0] EN_MIN_CYC =
        RATE_CNT_W'(EN_MIN_CYC_I);
    localparam logic [RATE_CNT_W-1:0] RATE_CNT_MAX = '1;

endpackage : vfd_pkg

// ### common/vfd_stream_if.sv
// Valid/ready word stream between the driver's own modules.
// Assumes both ends share one clock; no crossing inside.
`timescale 1ns/1ps
interface vfd_stream_if #(
    parameter int WIDTH = 4
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : vfd_stream_if

// ### design/vfd_driver.sv
// Serial-input display driver core: shift register, display register,
// start-bit or enable-strobe transfer, blanking and serial output.
// Assumes all pin inputs are asynchronous to clock; the shift clock is
// sampled and its edges found here. No bus: status bits are ports.
// Limit: each shift-clock phase needs 3+ system cycles.
//
// Function
// - Start variant: data, clock lines, 35 outputs
// - Serial input sampled on each rising edge
// - Start bit walks the 35-bit register
// - 36th rise transfers data, sets control latch
// - Next falling edge clears shift register
// - Start variant has no serial output
// - Enable variant: three lines, 20 or 32 outputs
// - Enable variant shifts on rise, no marker
// - Enable falling loads display register
// - Serial output is last shift stage
// - Enable variant: blank forces outputs off, data kept; start variant ignores blank
`timescale 1ns/1ps
module vfd_driver #(
    parameter vfd_pkg::vfd_mode_type MODE    = vfd_pkg::VFD_MODE_START,
    parameter int                    NUM_OUT = vfd_pkg::START_OUTPUTS,
    parameter int                    DEPTH   = vfd_pkg::FIFO_DEPTH
) (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               clk_en,
    input  wire logic               ser_data_pin,
    input  wire logic               shift_clk_pin,
    input  wire logic               enable_pin,
    input  wire logic               blank_pin,
    input  wire logic               hold_update,
    input  wire logic               clear_status,
    output logic      [NUM_OUT-1:0] disp_out,
    output logic                    serial_out,
    output logic                    control_latch,
    output logic                    frame_loaded,
    output logic                    overrun,
    output logic                    rate_error,
    output logic                    fifo_ready
);
    import vfd_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_ARMED
    } vfd_state_type;

    // Shortest legal rise gap
    localparam logic [RATE_CNT_W-1:0] MIN_GAP =
        (MODE == VFD_MODE_START) ? START_MIN_CYC : EN_MIN_CYC;
    localparam logic                  IS_EN   = (MODE == VFD_MODE_ENABLE);

    // Synced pins, edges
    logic [SYNC_W-1:0]     pins_s;
    logic                  clk_d;
    logic                  en_d;
    logic                  next_clk_d;
    logic                  next_en_d;
    logic                  clk_rise;
    logic                  clk_fall;
    logic                  en_fall;
    logic                  ev_any;
    logic                  ev_shift;

    // Datapath
    logic [NUM_OUT-1:0]    sr;
    logic [NUM_OUT-1:0]    disp_reg;
    vfd_state_type         state;
    logic [NUM_OUT-1:0]    next_sr;
    logic [NUM_OUT-1:0]    next_disp_reg;
    logic [NUM_OUT-1:0]    next_disp_out;
    vfd_state_type         next_state;
    logic                  next_ctl;
    logic                  next_loaded;
    logic                  next_ser;
    logic [WORD_W-1:0]     word;
    logic                  take;

    // Status
    logic [RATE_CNT_W-1:0] gap_cnt;
    logic [RATE_CNT_W-1:0] next_gap_cnt;
    logic                  next_overrun;
    logic                  next_rate_error;
    logic                  next_fifo_ready;

    // FIFO links
    vfd_stream_if #(.WIDTH(WORD_W)) wr_if ();
    vfd_stream_if #(.WIDTH(WORD_W)) rd_if ();

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Lanes in P_* order
    vfd_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in ({blank_pin, enable_pin, shift_clk_pin, ser_data_pin}),
        .sync_out (pins_s)
    );

    // ------------------------------------------------------------------
    // Edge finding on the sampled shift clock and enable
    // ------------------------------------------------------------------
    // Level now against last cycle's copy
    always_comb begin
        next_clk_d = pins_s[P_CLK];
        next_en_d  = pins_s[P_EN];
        clk_rise   = pins_s[P_CLK] && !clk_d;
        clk_fall   = !pins_s[P_CLK] && clk_d;
        // Enable edges count in enable mode only
        en_fall    = IS_EN && !pins_s[P_EN] && en_d;

        // Enable variant only takes bits while enable is high
        ev_shift   = clk_rise && (!IS_EN || pins_s[P_EN]);
        ev_any     = ev_shift || en_fall || (clk_fall && !IS_EN);
    end

    // Low after reset: no false rise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clk_d <= 1'b0;
            en_d  <= 1'b0;
        end else if (clk_en) begin
            clk_d <= next_clk_d;
            en_d  <= next_en_d;
        end
    end

    // ------------------------------------------------------------------
    // Event words into the FIFO
    // ------------------------------------------------------------------
    // Edges of one sample share a word, so one push per cycle suffices
    always_comb begin
        wr_if.valid          = ev_any;
        wr_if.data           = '0;
        wr_if.data[W_DATA]   = pins_s[P_DATA];
        wr_if.data[W_SHIFT]  = ev_shift;
        wr_if.data[W_LOAD]   = en_fall;
        wr_if.data[W_FALL]   = clk_fall && !IS_EN;
    end

    // Queue decouples capture and hold
    vfd_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .wr     (wr_if),
        .rd     (rd_if)
    );

    // Holding updates stalls the drain; the FIFO then really fills
    assign rd_if.ready = !hold_update;

    // ------------------------------------------------------------------
    // Shift and display registers
    // ------------------------------------------------------------------
    always_comb begin
        next_sr       = sr;
        next_disp_reg = disp_reg;
        next_state    = state;
        next_ctl      = control_latch;
        next_loaded   = 1'b0;
        word          = rd_if.data;
        take          = rd_if.valid && rd_if.ready;

        if (take && !IS_EN) begin
            if (word[W_SHIFT]) begin
                case (state)
                    ST_IDLE: begin
                        next_sr = {sr[NUM_OUT-2:0], word[W_DATA]};
                        // Zeros before the start bit are harmless
                        if (word[W_DATA]) begin
                            next_state = ST_LOAD;
                        end
                    end
                    ST_LOAD: begin
                        if (sr[NUM_OUT-1]) begin
                            // Start bit reached last stage: 36th rise
                            next_disp_reg = {sr[NUM_OUT-2:0],
                                             word[W_DATA]};
                            next_ctl      = 1'b1;
                            next_loaded   = 1'b1;
                            next_state    = ST_ARMED;
                        end else begin
                            next_sr = {sr[NUM_OUT-2:0],
                                       word[W_DATA]};
                        end
                    end
                    ST_ARMED: begin
                        // Rises before the clearing fall are dropped
                        next_state = ST_ARMED;
                    end
                    // Stray code: back to idle
                    default: begin
                        next_state = ST_IDLE;
                    end
                endcase
            end
            // Fall clears only once armed
            if (word[W_FALL] && next_state == ST_ARMED) begin
                next_sr    = '0;
                next_ctl   = 1'b0;
                next_state = ST_IDLE;
            end
        end else if (take) begin
            // Strobe takes the fresh register
            if (word[W_SHIFT]) begin
                next_sr = {sr[NUM_OUT-2:0], word[W_DATA]};
            end
            if (word[W_LOAD]) begin
                next_disp_reg = next_sr;
                next_loaded   = 1'b1;
            end
        end

        // Only the enable variant has a serial tap
        next_ser      = IS_EN ? next_sr[NUM_OUT-1] : 1'b0;
        // Blank masks the pins only; disp_reg is untouched
        next_disp_out = (IS_EN && pins_s[P_BLANK]) ? '0
                                                   : next_disp_reg;
    end

    // Every output is a flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sr            <= '0;
            disp_reg      <= '0;
            disp_out      <= '0;
            state         <= ST_IDLE;
            control_latch <= 1'b0;
            frame_loaded  <= 1'b0;
            serial_out    <= 1'b0;
        end else if (clk_en) begin
            sr            <= next_sr;
            disp_reg      <= next_disp_reg;
            disp_out      <= next_disp_out;
            state         <= next_state;
            control_latch <= next_ctl;
            frame_loaded  <= next_loaded;
            serial_out    <= next_ser;
        end
    end

    // ------------------------------------------------------------------
    // Status: overrun and shift-clock rate check
    // ------------------------------------------------------------------
    // A fresh event beats a clear in the same cycle
    always_comb begin
        next_overrun    = (ev_any && !wr_if.ready)
                       || (overrun && !clear_status);

        // Rise gap, saturating
        if (clk_rise) begin
            next_gap_cnt = '0;
        end else if (gap_cnt != RATE_CNT_MAX) begin
            next_gap_cnt = gap_cnt + 1'b1;
        end else begin
            next_gap_cnt = gap_cnt;
        end

        // Gap in cycles is gap_cnt + 1; too short flags the host
        next_rate_error = (clk_rise && (gap_cnt < MIN_GAP - 1'b1))
                       || (rate_error && !clear_status);

        // Trails the FIFO one cycle
        next_fifo_ready = wr_if.ready;
    end

    // Counter parks at top: first rise is clean
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overrun    <= 1'b0;
            rate_error <= 1'b0;
            gap_cnt    <= RATE_CNT_MAX;
            fifo_ready <= 1'b0;
        end else if (clk_en) begin
            overrun    <= next_overrun;
            rate_error <= next_rate_error;
            gap_cnt    <= next_gap_cnt;
            fifo_ready <= next_fifo_ready;
        end
    end

endmodule : vfd_driver

// ### design/vfd_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
module vfd_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input  wire logic   clock,
    input  wire logic   rst,
    input  wire logic   clk_en,
    vfd_stream_if.snk   wr,
    vfd_stream_if.src   rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             full;
    logic             empty;
    logic             do_wr;
    logic             do_rd;

    // ------------------------------------------------------------------
    // Flags from pointers; extra bit tells full from empty
    // ------------------------------------------------------------------
    always_comb begin
        empty       = (wr_ptr == rd_ptr);
        full        = (wr_ptr[AW] != rd_ptr[AW])
                   && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
        do_wr       = wr.valid && !full;
        do_rd       = rd.ready && !empty;
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    end

    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[rd_ptr[AW-1:0]];

    // ------------------------------------------------------------------
    // Pointers and storage
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (clk_en) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage carries no reset; read only when not empty
    always_ff @(posedge clock) begin
        if (clk_en && do_wr) begin
            mem[wr_ptr[AW-1:0]] <= wr.data;
        end
    end
endmodule : vfd_fifo

// ### design/vfd_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes each lane is an independent level; no bus coherence.
`timescale 1ns/1ps
module vfd_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------------
    // Two flops; only the second stage is seen outside
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : vfd_sync

// ### sim/tb.sv
// Bench: one start-bit and one enable driver, each fed by a host model.
// Assumes a 25 MHz clock; status inputs are driven here.
`timescale 1ns/1ps
module tb;
    import vfd_pkg::*;
    localparam int NS = START_OUTPUTS;
    localparam int NE = EN_OUTPUTS_LARGE;
    localparam int LIMIT = 20000;        // Run needs about 1300 cycles
    localparam logic [NS-1:0] FRM_A = 35'h6a5c39e17;
    localparam logic [NS-1:0] FRM_B = 35'h7c3a5f0e9;
    localparam logic [NE-1:0] WRD_C = 32'hb38e51c6;
    logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic hold_s = 1'b0, hold_e = 1'b0, clr_s = 1'b0, clr_e = 1'b0;
    logic dat_s, sck_s, en_s, blk_s, dat_e, sck_e, en_e, blk_e;
    logic [NS-1:0] disp_s;
    logic [NE-1:0] disp_e;
    logic sout_s, lat_s, fl_s, ovr_s, rate_s, rdy_s;
    logic sout_e, lat_e, fl_e, ovr_e, rate_e, rdy_e;
    int err_count = 0, num_checks = 0, loads_s = 0, loads_e = 0;
    int cycles = 0;
    // ------------------------------------------------------------------
    // Clock, devices and hosts
    // ------------------------------------------------------------------
    always #20 clock = ~clock;
    vfd_host_model #(.NUM_OUT(NS), .USE_EN(1'b0)) u_vfd_host_model (
        .clock(clock), .ser_data_pin(dat_s), .shift_clk_pin(sck_s),
        .enable_pin(en_s), .blank_pin(blk_s));
    vfd_host_model #(.NUM_OUT(NE), .USE_EN(1'b1)) u_vfd_host_model_en (
        .clock(clock), .ser_data_pin(dat_e), .shift_clk_pin(sck_e),
        .enable_pin(en_e), .blank_pin(blk_e));
    vfd_driver #(.MODE(VFD_MODE_START), .NUM_OUT(NS), .DEPTH(FIFO_DEPTH))
    u_vfd_driver (.clock(clock), .rst(rst), .clk_en(clk_en),
        .ser_data_pin(dat_s), .shift_clk_pin(sck_s), .enable_pin(en_s),
        .blank_pin(blk_s), .hold_update(hold_s), .clear_status(clr_s),
        .disp_out(disp_s), .serial_out(sout_s), .control_latch(lat_s),
        .frame_loaded(fl_s), .overrun(ovr_s), .rate_error(rate_s),
        .fifo_ready(rdy_s));
    vfd_driver #(.MODE(VFD_MODE_ENABLE), .NUM_OUT(NE), .DEPTH(FIFO_DEPTH))
    u_vfd_driver_en (.clock(clock), .rst(rst), .clk_en(clk_en),
        .ser_data_pin(dat_e), .shift_clk_pin(sck_e), .enable_pin(en_e),
        .blank_pin(blk_e), .hold_update(hold_e), .clear_status(clr_e),
        .disp_out(disp_e), .serial_out(sout_e), .control_latch(lat_e),
        .frame_loaded(fl_e), .overrun(ovr_e), .rate_error(rate_e),
        .fifo_ready(rdy_e));
    // Load pulses counted; a hang is cut short by the cycle ceiling
    always @(posedge clock) begin
        if (fl_s === 1'b1) loads_s++;
        if (fl_e === 1'b1) loads_e++;
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                         input string msg);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Back-to-back frames: stale ones would fire an early transfer
    task automatic t_start_frames();
        int l0;
        l0 = loads_s;
        u_vfd_host_model.send_word(FRM_A, 1'b1, 1'b0);
        repeat (8) @(posedge clock);
        check(disp_s, FRM_A, "start frame A");
        check(lat_s, 1'b0, "latch after fall");
        check(sout_s, 1'b0, "serial out in start mode");
        check(rate_s, 1'b1, "fast shift clock flag");
        clr_s <= 1'b1;
        @(posedge clock);
        clr_s <= 1'b0;
        repeat (2) @(posedge clock);
        check(rate_s, 1'b0, "rate flag cleared");
        u_vfd_host_model.send_word(FRM_B, 1'b1, 1'b0);
        repeat (8) @(posedge clock);
        check(disp_s, FRM_B, "start frame B");
        check(loads_s, l0 + 2, "one load per frame");
    endtask : t_start_frames
    // Shift with enable held, one extra bit, then strobe low
    task automatic t_enable_load();
        int l0;
        l0 = loads_e;
        u_vfd_host_model_en.send_word(WRD_C, 1'b0, 1'b0);
        repeat (8) @(posedge clock);
        check(disp_e, '0, "no load while enable high");
        check(sout_e, WRD_C[31], "serial out last stage");
        u_vfd_host_model_en.send_bit(1'b0);
        repeat (8) @(posedge clock);
        check(sout_e, WRD_C[30], "serial out next bit");
        u_vfd_host_model_en.set_enable(1'b0);
        repeat (10) @(posedge clock);
        check(disp_e, {WRD_C[30:0], 1'b0}, "enable load");
        check(loads_e, l0 + 1, "single load pulse");
    endtask : t_enable_load
    // Blank hides the pattern, which then returns intact
    task automatic t_blank();
        u_vfd_host_model_en.set_blank(1'b1);
        repeat (6) @(posedge clock);
        check(disp_e, '0, "blanked");
        u_vfd_host_model_en.set_blank(1'b0);
        repeat (6) @(posedge clock);
        check(disp_e, {WRD_C[30:0], 1'b0}, "pattern back");
    endtask : t_blank
    // Scan bit strobed in; a frozen clock enable keeps blank out
    task automatic t_scan_freeze();
        u_vfd_host_model_en.send_word(32'h8000_0000, 1'b0, 1'b1);
        repeat (10) @(posedge clock);
        clk_en <= 1'b0;
        hold_s <= 1'b1;
        u_vfd_host_model_en.set_blank(1'b1);
        u_vfd_host_model.set_blank(1'b1);
        repeat (6) @(posedge clock);
        check(disp_e, 32'h8000_0000, "frozen");
        clk_en <= 1'b1;
        repeat (6) @(posedge clock);
        check(disp_e, '0, "blank after thaw");
        check(disp_s, FRM_B, "start ignores blank");
        hold_s <= 1'b0;
        u_vfd_host_model_en.set_blank(1'b0);
    endtask : t_scan_freeze
    // Stall the drain: 10 rise words into 8 places
    task automatic t_overrun();
        hold_e <= 1'b1;
        u_vfd_host_model_en.set_enable(1'b1);
        repeat (10) u_vfd_host_model_en.send_bit(1'b1);
        @(posedge clock);
        check(rdy_e, 1'b0, "fifo full");
        check(ovr_e, 1'b1, "overrun flagged");
        hold_e <= 1'b0;
        repeat (20) @(posedge clock);
        check(rdy_e, 1'b1, "fifo drained");
        clr_e <= 1'b1;
        @(posedge clock);
        clr_e <= 1'b0;
        repeat (2) @(posedge clock);
        check(ovr_e, 1'b0, "overrun cleared");
    endtask : t_overrun
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_start_frames();
        t_enable_load();
        t_blank();
        t_scan_freeze();
        t_overrun();
        give_verdict();
    end
endmodule : tb

// ### sim/vfd_driver_props.sv
// Port checker for the display driver: transfer, blanking, status.
// Assumes it is bound onto every driver instance of either mode.
`timescale 1ns/1ps
module vfd_driver_props #(
    parameter vfd_pkg::vfd_mode_type MODE    = vfd_pkg::VFD_MODE_START,
    parameter int                    NUM_OUT = vfd_pkg::START_OUTPUTS,
    parameter int                    DEPTH   = vfd_pkg::FIFO_DEPTH
) (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               clk_en,
    input wire logic               ser_data_pin,
    input wire logic               shift_clk_pin,
    input wire logic               enable_pin,
    input wire logic               blank_pin,
    input wire logic               hold_update,
    input wire logic               clear_status,
    input wire logic [NUM_OUT-1:0] disp_out,
    input wire logic               serial_out,
    input wire logic               control_latch,
    input wire logic               frame_loaded,
    input wire logic               overrun,
    input wire logic               rate_error,
    input wire logic               fifo_ready
);
    import vfd_pkg::*;
    localparam logic IS_ST = (MODE == VFD_MODE_START);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    start_sout_zero_a: assert property (IS_ST |-> !serial_out)
        else $error("serial output active in start mode");
    en_latch_zero_a: assert property (!IS_ST |-> !control_latch)
        else $error("control latch set in enable mode");
    blank_dark_a: assert property (!IS_ST && (blank_pin && clk_en) [*5] |->
        disp_out == '0)
        else $error("outputs lit while blanked");
    load_pulse_a: assert property (frame_loaded |=> !frame_loaded)
        else $error("load pulse longer than one cycle");
    start_disp_hold_a: assert property (IS_ST && $changed(disp_out) |->
        frame_loaded)
        else $error("display changed without a transfer");
    latch_load_a: assert property ($rose(control_latch) |->
        frame_loaded)
        else $error("latch set apart from transfer");
    latch_clear_a: assert property ($rose(control_latch) |->
        ##[1:40] !control_latch)
        else $error("latch not cleared after falling edge");
    en_load_a: assert property (!IS_ST && $fell(enable_pin) |->
        ##[1:12] frame_loaded)
        else $error("no load after enable fell");
    ovr_sticky_a: assert property (overrun && !clear_status |=> overrun)
        else $error("overrun dropped without clear");
    rate_sticky_a: assert property (rate_error && !clear_status |=>
        rate_error)
        else $error("rate flag dropped without clear");
    // Main scenarios reached
    cover property (IS_ST && frame_loaded);
    cover property (!IS_ST && frame_loaded);
    cover property ($rose(overrun));
    cover property ($rose(rate_error));
endmodule : vfd_driver_props

bind vfd_driver vfd_driver_props #(
    .MODE(MODE), .NUM_OUT(NUM_OUT), .DEPTH(DEPTH)
) u_vfd_driver_props (
    .clock(clock), .rst(rst), .clk_en(clk_en),
    .ser_data_pin(ser_data_pin), .shift_clk_pin(shift_clk_pin),
    .enable_pin(enable_pin), .blank_pin(blank_pin),
    .hold_update(hold_update), .clear_status(clear_status),
    .disp_out(disp_out), .serial_out(serial_out),
    .control_latch(control_latch), .frame_loaded(frame_loaded),
    .overrun(overrun), .rate_error(rate_error), .fifo_ready(fifo_ready)
);

// ### sim/vfd_host_model.sv
// Host pin model: shift clock, serial data, enable and blank lines.
// Assumes its tasks are called just after a rising system clock edge.
`timescale 1ns/1ps
module vfd_host_model #(
    parameter int   NUM_OUT = 35,
    parameter logic USE_EN  = 1'b0,
    parameter int   HALF    = 4          // 4 high + 4 low: 320 ns
) (
    input  wire logic clock,
    output logic      ser_data_pin,
    output logic      shift_clk_pin,
    output logic      enable_pin,
    output logic      blank_pin
);
    // Idle lines; shift clock parked low outside frames
    initial begin
        ser_data_pin  = 1'b0;
        shift_clk_pin = 1'b0;
        enable_pin    = 1'b0;
        blank_pin     = 1'b0;
    end
    // One bit: data set half a period ahead of the rise
    task automatic send_bit(input logic b);
        ser_data_pin <= b;
        repeat (HALF) @(posedge clock);
        shift_clk_pin <= 1'b1;
        repeat (HALF) @(posedge clock);
        shift_clk_pin <= 1'b0;
    endtask : send_bit
    // Whole word MSB first; load low keeps enable high for chaining
    task automatic send_word(input logic [NUM_OUT-1:0] v,
                             input logic lead, input logic load);
        if (USE_EN) begin
            enable_pin <= 1'b1;
            @(posedge clock);
        end
        if (lead) send_bit(1'b1);
        for (int i = NUM_OUT - 1; i >= 0; i--) send_bit(v[i]);
        @(posedge clock);
        ser_data_pin <= ~ser_data_pin;  // Inverted after the last bit: no stale level
        if (USE_EN && load) enable_pin <= 1'b0;
    endtask : send_word
    task automatic set_enable(input logic b);
        @(posedge clock);
        enable_pin <= b;
    endtask : set_enable
    task automatic set_blank(input logic b);
        @(posedge clock);
        blank_pin <= b;
    endtask : set_blank
endmodule : vfd_host_model
